// [hdl/htrc_pkg.sv]
// package for the host channel transfer result classifier
// assumes a single 20 MHz clock domain and an ahb-lite register slave
package htrc_pkg;

   localparam logic [2:0] CODE_CLEAN  = 3'h0;
   localparam logic [2:0] CODE_STALL  = 3'h1;
   localparam logic [2:0] CODE_MUCH   = 3'h2;
   localparam logic [2:0] CODE_SHORT  = 3'h3;
   localparam logic [2:0] CODE_RETRY  = 3'h4;

   // result field sits in bits 6..4 of the result register
   localparam int RESULT_LSB = 4;
   localparam int RESULT_MSB = 6;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   // byte addresses on the bus
   localparam logic [7:0] ADDR_RESULT = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK   = 8'h08;

   localparam logic [1:0] NYET_LIMIT = 2'h3;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [2:0] SIZE_WORD   = 3'h2;

   // one completed transaction as reported by the serial engine
   typedef struct packed {
      logic       done;
      logic       stall;
      logic       too_long;
      logic       over_total;
      logic       short_pkt;
      logic       under_total;
      logic       timeout;
      logic       crc_err;
      logic       stuff_err;
      logic       pid_check_err;
      logic       pid_invalid;
      logic       split_intr;
      logic       err_hs;
      logic       nyet_hs;
      logic       toggle_bad;
   } htrc_txn_t;

   typedef struct packed {
      logic [2:0]  code;
      logic [1:0]  nyet_cnt;
      logic        stat;
      logic        mask;
      logic        irq;
      logic        dphase;
      logic        dwrite;
      logic [7:0]  daddr;
      logic [31:0] rdata;
   } htrc_state_t;

endpackage : htrc_pkg

// [hdl/htrc_top.sv]
// transfer result classifier for one host channel, with ahb-lite regs
// assumes transaction outcome flags are synchronous and valid with done
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module htrc_top (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire htrc_pkg::htrc_txn_t txn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic                   irq
);

   htrc_pkg::htrc_state_t st_reg;
   htrc_pkg::htrc_state_t st_next;

   // the completion that makes the third nyet in a row
   function automatic logic nyet_third(
      input htrc_pkg::htrc_txn_t t,
      input logic [1:0]          nyet_cnt);
      nyet_third = t.split_intr && t.nyet_hs &&
                   (nyet_cnt == htrc_pkg::NYET_LIMIT - 2'h1);
   endfunction

   // a data-phase write to the given register offset
   function automatic logic write_hit(
      input htrc_pkg::htrc_state_t s,
      input logic [7:0]            addr);
      write_hit = s.dphase && s.dwrite && (s.daddr == addr);
   endfunction

   // classification priority: retry faults first, then stall, then sizes
   function automatic logic [2:0] classify(
      input htrc_pkg::htrc_txn_t t,
      input logic [1:0]          nyet_cnt);
      logic nyet_fail;
      logic retry;
      nyet_fail = nyet_third(t, nyet_cnt);
      // timeout, crc, stuffing, pid check, pid, split err, third nyet, toggle
      retry = t.timeout || t.crc_err || t.stuff_err ||
              t.pid_check_err || t.pid_invalid ||
              (t.split_intr && t.err_hs) || nyet_fail || t.toggle_bad;
      // crc/stuffing beats over/underrun, covered by retry first
      if (retry)
         classify = htrc_pkg::CODE_RETRY;
      else if (t.stall)
         classify = htrc_pkg::CODE_STALL;
      // overrun; toggle case already taken above
      else if (t.too_long || t.over_total)
         classify = htrc_pkg::CODE_MUCH;
      else if (t.short_pkt && t.under_total)
         classify = htrc_pkg::CODE_SHORT;
      else
         classify = htrc_pkg::CODE_CLEAN;
   endfunction

   always_comb begin
      logic [7:0]  res_byte;
      logic        wr_stat;
      logic        wr_mask;
      res_byte = '0;
      st_next  = st_reg;
      wr_stat  = write_hit(st_reg, htrc_pkg::ADDR_STATUS);
      wr_mask  = write_hit(st_reg, htrc_pkg::ADDR_MASK);
      if (txn.done) begin
         st_next.code = classify(txn, st_reg.nyet_cnt);
         if (txn.split_intr && txn.nyet_hs &&
             !nyet_third(txn, st_reg.nyet_cnt))
            st_next.nyet_cnt = st_reg.nyet_cnt + 2'h1;
         else
            st_next.nyet_cnt = '0;
      end
      if (wr_mask)
         st_next.mask = hwdata[0];
      // set wins over write-one-to-clear
      if (wr_stat && hwdata[0])
         st_next.stat = 1'b0;
      if (txn.done)
         st_next.stat = 1'b1;
      st_next.irq = st_next.stat && st_next.mask;
      // address phase capture; single-cycle data phase, never waits
      // only whole-word single transfers are taken
      st_next.dphase = hsel && hready && (htrans == htrc_pkg::TRANS_NONSEQ) &&
                       (hsize == htrc_pkg::SIZE_WORD);
      st_next.dwrite = hwrite;
      st_next.daddr  = haddr[7:0];
      st_next.rdata  = '0;
      if (st_next.dphase && !hwrite) begin
         res_byte[htrc_pkg::RESULT_MSB:htrc_pkg::RESULT_LSB] = st_next.code;
         unique case (haddr[7:0])
            htrc_pkg::ADDR_RESULT: st_next.rdata = {24'h000000, res_byte};
            htrc_pkg::ADDR_STATUS: st_next.rdata = {31'h0, st_next.stat};
            htrc_pkg::ADDR_MASK:   st_next.rdata = {31'h0, st_next.mask};
            default:               st_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign hrdata    = st_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign irq       = st_reg.irq;

   // steps of the interrupt split nyet run
   sequence nyet_seen_s;
      txn.done && txn.split_intr && txn.nyet_hs;
   endsequence

   sequence nyet_third_s;
      (st_reg.nyet_cnt == htrc_pkg::NYET_LIMIT - 2'h1) ##0 nyet_seen_s;
   endsequence

   sequence nyet_early_s;
      (st_reg.nyet_cnt != htrc_pkg::NYET_LIMIT - 2'h1) ##0 nyet_seen_s;
   endsequence

   stall_code_a: assert property (@(posedge clk) disable iff (!reset_n)
      txn.done && txn.stall && !txn.timeout && !txn.crc_err &&
      !txn.stuff_err && !txn.pid_check_err && !txn.pid_invalid &&
      !txn.toggle_bad && !(txn.split_intr && (txn.err_hs || txn.nyet_hs))
      |=> st_reg.code == htrc_pkg::CODE_STALL)
      else $error("stall not reported");

   crc_retry_a: assert property (@(posedge clk) disable iff (!reset_n)
      txn.done && (txn.crc_err || txn.stuff_err) && txn.too_long
      |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("crc with overrun not retry");

   timeout_retry_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.timeout |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("timeout not retry");

   toggle_retry_a: assert property (@(posedge clk) disable iff (!reset_n)
      txn.done && txn.toggle_bad && txn.over_total
      |=> st_reg.code != htrc_pkg::CODE_MUCH)
      else $error("toggle mismatch reported as overrun");

   code_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      !txn.done |=> $stable(st_reg.code))
      else $error("result changed without completion");

   code_legal_a: assert property (@(posedge clk) disable iff (!reset_n)
      st_reg.code <= htrc_pkg::CODE_RETRY)
      else $error("reserved result code");

   err_split_a: assert property (@(posedge clk) disable iff (!reset_n)
      txn.done && txn.split_intr && txn.err_hs
      |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("split err not retry");

   nyet_three_a: assert property (@(posedge clk) disable iff (!reset_n)
      nyet_third_s |=> st_reg.code == htrc_pkg::CODE_RETRY &&
                       st_reg.nyet_cnt == 2'h0)
      else $error("third nyet not retry");

   nyet_count_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      nyet_early_s |=> st_reg.nyet_cnt == $past(st_reg.nyet_cnt) + 2'h1)
      else $error("nyet run not counted");

   nyet_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && !(txn.split_intr && txn.nyet_hs)
      |=> st_reg.nyet_cnt == 2'h0)
      else $error("nyet run not cleared");

   irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      txn.done ##1 st_reg.mask |-> ##1 irq)
      else $error("irq missing");

   // check terms from the rules; the result read and write and the status clear below exclude a completion
   // in the same cycle, since the new code would then be seen instead
   logic chk_retry_h;
   logic chk_size_h;
   assign chk_retry_h = txn.timeout || txn.crc_err || txn.stuff_err ||
                        txn.pid_check_err || txn.pid_invalid ||
                        txn.toggle_bad || (txn.split_intr && txn.err_hs) ||
                        (txn.split_intr && txn.nyet_hs &&
                         st_reg.nyet_cnt == htrc_pkg::NYET_LIMIT - 2'h1);
   assign chk_size_h  = txn.too_long || txn.over_total ||
                        (txn.short_pkt && txn.under_total);

   retry_wins_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && chk_retry_h |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("retry cause not reported");

   stall_wins_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.stall && !chk_retry_h
      |=> st_reg.code == htrc_pkg::CODE_STALL)
      else $error("stall lost to a size case");

   clean_code_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && !chk_retry_h && !txn.stall && !chk_size_h
      |=> st_reg.code == htrc_pkg::CODE_CLEAN)
      else $error("clean completion not reported");

   long_pkt_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.too_long && !chk_retry_h && !txn.stall
      |=> st_reg.code == htrc_pkg::CODE_MUCH)
      else $error("long packet not overrun");

   over_total_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.over_total && !chk_retry_h && !txn.stall
      |=> st_reg.code == htrc_pkg::CODE_MUCH)
      else $error("bytes beyond total not overrun");

   short_data_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.short_pkt && txn.under_total && !txn.too_long &&
      !txn.over_total && !chk_retry_h && !txn.stall
      |=> st_reg.code == htrc_pkg::CODE_SHORT)
      else $error("short packet not underrun");

   stuff_under_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && (txn.crc_err || txn.stuff_err) &&
      (txn.over_total || (txn.short_pkt && txn.under_total))
      |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("damaged size case not retry");

   crc_data_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.crc_err |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("crc failure not retry");

   stuff_data_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.stuff_err |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("stuffing violation not retry");

   pid_check_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.pid_check_err |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("pid check failure not retry");

   pid_bad_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.pid_invalid |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("invalid pid not retry");

   toggle_bad_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done && txn.toggle_bad |=> st_reg.code == htrc_pkg::CODE_RETRY)
      else $error("toggle mismatch not retry");

   sequence result_read_s;
      hsel && hready && htrans == htrc_pkg::TRANS_NONSEQ &&
      hsize == htrc_pkg::SIZE_WORD && !hwrite &&
      haddr[7:0] == htrc_pkg::ADDR_RESULT && !txn.done;
   endsequence

   result_read_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      result_read_s |=> hrdata == (32'(st_reg.code) << htrc_pkg::RESULT_LSB))
      else $error("result field misplaced");

   sequence result_write_s;
      st_reg.dphase && st_reg.dwrite &&
      st_reg.daddr == htrc_pkg::ADDR_RESULT && !txn.done;
   endsequence

   result_ro_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      result_write_s |=> $stable(st_reg.code))
      else $error("result register took a write");

   reset_value_a: assert property (
      @(posedge clk)
      !reset_n && !$past(reset_n) |-> st_reg.code == htrc_pkg::CODE_CLEAN &&
      hrdata == '0 && !irq)
      else $error("reset value wrong");

   sequence spare_read_s;
      hsel && hready && htrans == htrc_pkg::TRANS_NONSEQ &&
      hsize == htrc_pkg::SIZE_WORD && !hwrite &&
      haddr[7:0] != htrc_pkg::ADDR_RESULT &&
      haddr[7:0] != htrc_pkg::ADDR_STATUS &&
      haddr[7:0] != htrc_pkg::ADDR_MASK;
   endsequence

   spare_read_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      spare_read_s |=> hrdata == '0)
      else $error("unmapped read not zero");

   status_set_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      txn.done |=> st_reg.stat && irq == st_reg.mask)
      else $error("completion not flagged");

   status_clear_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      write_hit(st_reg, htrc_pkg::ADDR_STATUS) && hwdata[0] && !txn.done
      |=> !st_reg.stat && !irq)
      else $error("status not cleared");

   mask_write_a: assert property (
      @(posedge clk) disable iff (!reset_n)
      write_hit(st_reg, htrc_pkg::ADDR_MASK)
      |=> st_reg.mask == $past(hwdata[0]))
      else $error("mask write lost");

endmodule : htrc_top

`default_nettype wire

// [test/htrc_endpoint_model.sv]
// endpoint stand-in: one completed transaction per go pulse
// assumes go and flags change just after the rising edge
`timescale 1ns/1ps
`default_nettype none
module htrc_endpoint_model (
   input  wire logic           clk,
   input  wire logic           reset_n,
   input  wire logic           go,
   input  wire logic [13:0]    flags,
   output var htrc_pkg::htrc_txn_t txn
);
   // flags only mean something with done, so they wander in between
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txn <= '0;
      end else begin
         txn <= go ? {1'b1, flags} : {1'b0, ~txn[13:0]};
      end
   end
endmodule // htrc_endpoint_model
`default_nettype wire

// [test/htrc_top_bench.sv]
// bench for the transfer result classifier: results, registers, irq
// assumes the bus slave answers with hreadyout and the endpoint model
`timescale 1ns/1ps
`default_nettype none
module htrc_top_bench;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        go = 1'b0;
   logic [13:0] flags = 14'h0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rdata;
   logic        hreadyout;
   logic        hresp;
   logic        irq;
   int          n_errors = 0;
   int          n_tests = 0;
   htrc_pkg::htrc_txn_t txn;
   // {code, stall too_long over short under tmo crc stuff pchk pinv
   //  split err nyet toggle}
   localparam logic [16:0] CASES [16] = '{
      {3'h0, 14'h0000}, {3'h1, 14'h2000},
      {3'h2, 14'h1000}, {3'h2, 14'h0800},
      {3'h3, 14'h0600}, {3'h4, 14'h0100},
      {3'h4, 14'h0080}, {3'h4, 14'h0040},
      {3'h4, 14'h0020}, {3'h4, 14'h0010},
      {3'h4, 14'h000c}, {3'h4, 14'h0001},
      {3'h4, 14'h1080}, {3'h4, 14'h0640},
      {3'h4, 14'h0801}, {3'h1, 14'h2000}};
   always #25 clk = ~clk;
   htrc_endpoint_model i_htrc_endpoint_model (.clk(clk), .reset_n(reset_n),
      .go(go), .flags(flags), .txn(txn));
   htrc_top i_htrc_top (.clk(clk), .reset_n(reset_n), .txn(txn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(htrc_pkg::SIZE_WORD), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= htrc_pkg::TRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdata = hrdata;
   endtask
   task automatic send(input logic [13:0] f);
      @(posedge clk);
      go <= 1'b1;
      flags <= f;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      test_done;
   end
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
      chk(rdata, 32'h0);
      chk({31'h0, irq}, 32'h0);
      chk({31'h0, hreadyout}, 32'h1);
      chk({31'h0, hresp}, 32'h0);
      foreach (CASES[i]) begin
         send(CASES[i][13:0]);
         bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
         chk(rdata, {25'h0, CASES[i][16:14], 4'h0});
      end
      // the result register must shrug off writes
      bus(1'b1, htrc_pkg::ADDR_RESULT, 32'hff);
      bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
      chk(rdata, 32'h10);
      send(14'h000a);
      send(14'h000a);
      send(14'h0000);
      send(14'h000a);
      send(14'h000a);
      bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
      chk(rdata, 32'h0);
      send(14'h000a);
      bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
      chk(rdata, 32'h40);
      bus(1'b1, htrc_pkg::ADDR_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, htrc_pkg::ADDR_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      send(14'h0000);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, htrc_pkg::ADDR_STATUS, 32'h0);
      chk(rdata, 32'h1);
      bus(1'b1, htrc_pkg::ADDR_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, 8'h0c, 32'h0);
      chk(rdata, 32'h0);
      // a reset in mid-run must bring back the cleared result
      send(14'h2000);
      bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
      chk(rdata, 32'h10);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      bus(1'b0, htrc_pkg::ADDR_RESULT, 32'h0);
      chk(rdata, 32'h0);
      bus(1'b0, htrc_pkg::ADDR_STATUS, 32'h0);
      chk(rdata, 32'h0);
      test_done;
   end
endmodule // htrc_top_bench
`default_nettype wire
